// ### bcfg_pkg.sv
// constants, types and field layout of the boot configuration decoder
package bcfg_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 26;
  localparam logic [23:0] IDX_CFG_BASE = 24'h30_0000;
  localparam logic [23:0] IDX_OSC_CFG = 24'h30_0001;
  localparam logic [23:0] IDX_RST_CFG = 24'h30_0002;
  localparam logic [23:0] IDX_CTRL = 24'h30_0010;
  localparam logic [23:0] IDX_STAT = 24'h30_0011;
  localparam logic [1:0] WORD_LSBS = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_OSC_CFG = {IDX_OSC_CFG, WORD_LSBS};
  localparam logic [ADDR_W-1:0] ADDR_RST_CFG = {IDX_RST_CFG, WORD_LSBS};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, WORD_LSBS};
  localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT, WORD_LSBS};

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int OSC_SWITCHOVER_BIT = 7;
  localparam int OSC_FAILSAFE_BIT = 6;
  localparam int OSC_SEL_MSB = 3;
  localparam int OSC_SEL_LSB = 0;
  localparam int RST_BOR_THR_MSB = 4;
  localparam int RST_BOR_THR_LSB = 3;
  localparam int RST_BOR_MODE_MSB = 2;
  localparam int RST_BOR_MODE_LSB = 1;
  localparam int RST_POWERUP_DELAY_TIMER_N_BIT = 0;
  localparam int CTRL_SW_BOR_BIT = 0;
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_BOR_ACTIVE_BIT = 1;
  localparam int STAT_POWERUP_DELAY_TIMER_RUN_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;

  // ----------------------------------------------------------------
  // masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OSC_IMPL_MASK = 8'hCF;
  localparam logic [7:0] RST_IMPL_MASK = 8'h1F;
  localparam logic [7:0] OSC_UNPROG = 8'h07;
  localparam logic [7:0] RST_UNPROG = 8'h1F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic CTRL_SW_BOR_RESET = 1'b0;
  localparam logic [2:0] SYNC_FILL_CYCLES = 3'h3;
  localparam logic [2:0] FILL_ZERO = 3'h0;
  localparam logic [2:0] FILL_STEP = 3'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BCFG_BOR_OFF = 2'b00,
    BCFG_BOR_SOFTWARE = 2'b01,
    BCFG_BOR_HW_AWAKE = 2'b10,
    BCFG_BOR_HW_ALWAYS = 2'b11
  } bcfg_bor_mode_type;

  typedef enum logic [1:0] {
    BCFG_LD_FILL = 2'b00,
    BCFG_LD_WAIT = 2'b01,
    BCFG_LD_DONE = 2'b10
  } bcfg_load_state_type;

endpackage : bcfg_pkg

// ### bcfg_sync3.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module bcfg_sync3 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // asynchronous input
  input wire logic [W-1:0] async_in,
  // synchronised output
  output logic [W-1:0] sync_out,
  output logic settled
);

  logic [W-1:0] agree;

  // ----------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_q, s2_q, s3_q, out_q, out_d;
    always_comb begin
      out_d = (s2_q == s3_q) ? s3_q : out_q;
    end
    always_ff @(posedge mclk) begin
      if (rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        out_q <= 1'b0;
      end else begin
        s1_q <= async_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        out_q <= out_d;
      end
    end
    assign sync_out[i] = out_q;
    assign agree[i] = (s2_q == s3_q);
  end

  // ----------------------------------------------------------------
  // settled flag
  // ----------------------------------------------------------------
  logic settled_q, settled_d;
  always_comb begin
    settled_d = &agree;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      settled_q <= 1'b0;
    end else begin
      settled_q <= settled_d;
    end
  end
  assign settled = settled_q;

endmodule : bcfg_sync3

// ### bcfg_top.sv
// boot configuration decoder: latches two stored bytes and drives clock and reset controls
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module bcfg_top
  import bcfg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile storage cells
  input wire logic [7:0] nv_osc_byte,
  input wire logic [7:0] nv_rst_byte,
  input wire logic nv_blank,
  // device power state
  input wire logic sleep_active,
  // decoded clock controls
  output logic clock_switchover_enable,
  output logic failsafe_monitor_enable,
  output logic [3:0] oscillator_select,
  // decoded reset controls
  output logic [1:0] brownout_threshold_select,
  output logic brownout_reset_active,
  output logic powerup_delay_run,
  output logic config_loaded
);

  // ----------------------------------------------------------------
  // storage input synchroniser
  // ----------------------------------------------------------------
  logic [16:0] nv_raw;
  logic [16:0] nv_sync;
  logic nv_settled;

  assign nv_raw = {nv_blank, nv_rst_byte, nv_osc_byte};

  // storage pins come from another domain, so they are filtered first
  bcfg_sync3 #(
    .W(17)
  ) u_nv_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(nv_raw),
    .sync_out(nv_sync),
    .settled(nv_settled)
  );

  logic [7:0] nv_osc_s;
  logic [7:0] nv_rst_s;
  logic nv_blank_s;

  assign nv_osc_s = nv_sync[7:0];
  assign nv_rst_s = nv_sync[15:8];
  assign nv_blank_s = nv_sync[16];

  // ----------------------------------------------------------------
  // loader state
  // ----------------------------------------------------------------
  bcfg_load_state_type ld_state_q, ld_state_d;
  logic [2:0] fill_cnt_q, fill_cnt_d;
  logic [7:0] osc_cfg_q, osc_cfg_d;
  logic [7:0] rst_cfg_q, rst_cfg_d;
  logic loaded_q, loaded_d;
  logic capture;

  // values are caught only after reset release, never under reset itself
  always_comb begin
    ld_state_d = ld_state_q;
    fill_cnt_d = fill_cnt_q;
    loaded_d = loaded_q;
    capture = 1'b0;
    unique case (ld_state_q)
      BCFG_LD_FILL: begin
        if (fill_cnt_q == SYNC_FILL_CYCLES) begin
          ld_state_d = BCFG_LD_WAIT;
        end else begin
          fill_cnt_d = fill_cnt_q + FILL_STEP;
        end
      end
      BCFG_LD_WAIT: begin
        if (nv_settled) begin
          ld_state_d = BCFG_LD_DONE;
          loaded_d = 1'b1;
          capture = 1'b1;
        end
      end
      BCFG_LD_DONE: begin
        // bytes stay frozen until the next reset
        ld_state_d = BCFG_LD_DONE;
      end
      default: begin
        ld_state_d = BCFG_LD_FILL;
        fill_cnt_d = FILL_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ld_state_q <= BCFG_LD_FILL;
      fill_cnt_q <= FILL_ZERO;
      loaded_q <= 1'b0;
    end else begin
      ld_state_q <= ld_state_d;
      fill_cnt_q <= fill_cnt_d;
      loaded_q <= loaded_d;
    end
  end

  // ----------------------------------------------------------------
  // captured bytes
  // ----------------------------------------------------------------
  // a blank part takes the unprogrammed pattern, not the floating cells
  always_comb begin
    osc_cfg_d = osc_cfg_q;
    rst_cfg_d = rst_cfg_q;
    if (capture && nv_blank_s) begin
      osc_cfg_d = OSC_UNPROG;
      rst_cfg_d = RST_UNPROG;
    end else if (capture) begin
      osc_cfg_d = nv_osc_s & OSC_IMPL_MASK;
      rst_cfg_d = nv_rst_s & RST_IMPL_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_cfg_q <= BYTE_ZERO;
      rst_cfg_q <= BYTE_ZERO;
    end else begin
      osc_cfg_q <= osc_cfg_d;
      rst_cfg_q <= rst_cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // software control register
  // ----------------------------------------------------------------
  logic sw_bor_q, sw_bor_d;
  logic acc_done;
  logic wr_ctrl;

  assign acc_done = psel && penable && pready;
  assign wr_ctrl = acc_done && pwrite && (paddr == ADDR_CTRL) && pstrb[0];

  // a write lands only at the completing edge of the access phase
  always_comb begin
    sw_bor_d = sw_bor_q;
    if (wr_ctrl) begin
      sw_bor_d = pwdata[CTRL_SW_BOR_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sw_bor_q <= CTRL_SW_BOR_RESET;
    end else begin
      sw_bor_q <= sw_bor_d;
    end
  end

  // ----------------------------------------------------------------
  // decoded clock controls
  // ----------------------------------------------------------------
  logic switch_q, switch_d;
  logic failsafe_q, failsafe_d;
  logic [3:0] osc_sel_q, osc_sel_d;

  // switchover and failsafe held off, select held at its reset value, until the bytes are loaded
  always_comb begin
    switch_d = 1'b0;
    failsafe_d = 1'b0;
    osc_sel_d = osc_sel_q;
    if (loaded_q) begin
      switch_d = osc_cfg_q[OSC_SWITCHOVER_BIT];
      failsafe_d = osc_cfg_q[OSC_FAILSAFE_BIT];
      osc_sel_d = osc_cfg_q[OSC_SEL_MSB:OSC_SEL_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      switch_q <= 1'b0;
      failsafe_q <= 1'b0;
      osc_sel_q <= OSC_UNPROG[OSC_SEL_MSB:OSC_SEL_LSB];
    end else begin
      switch_q <= switch_d;
      failsafe_q <= failsafe_d;
      osc_sel_q <= osc_sel_d;
    end
  end

  // ----------------------------------------------------------------
  // decoded trip level and power-up delay
  // ----------------------------------------------------------------
  logic [1:0] bor_thr_q, bor_thr_d;
  logic powerup_delay_timer_run_q, powerup_delay_timer_run_d;

  // power-up delay looks at its own bit only, never a brown-out field
  always_comb begin
    bor_thr_d = bor_thr_q;
    powerup_delay_timer_run_d = 1'b0;
    if (loaded_q) begin
      bor_thr_d = rst_cfg_q[RST_BOR_THR_MSB:RST_BOR_THR_LSB];
      powerup_delay_timer_run_d = ~rst_cfg_q[RST_POWERUP_DELAY_TIMER_N_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bor_thr_q <= RST_UNPROG[RST_BOR_THR_MSB:RST_BOR_THR_LSB];
      powerup_delay_timer_run_q <= 1'b0;
    end else begin
      bor_thr_q <= bor_thr_d;
      powerup_delay_timer_run_q <= powerup_delay_timer_run_d;
    end
  end

  // ----------------------------------------------------------------
  // decoded brown-out enable
  // ----------------------------------------------------------------
  bcfg_bor_mode_type bor_mode;
  logic bor_act_q, bor_act_d;

  assign bor_mode = bcfg_bor_mode_type'(rst_cfg_q[RST_BOR_MODE_MSB:RST_BOR_MODE_LSB]);

  // sleep and software only count in the modes that name them
  always_comb begin
    bor_act_d = 1'b0;
    if (loaded_q) begin
      unique case (bor_mode)
        BCFG_BOR_HW_ALWAYS: begin
          bor_act_d = 1'b1;
        end
        BCFG_BOR_HW_AWAKE: begin
          bor_act_d = ~sleep_active;
        end
        BCFG_BOR_SOFTWARE: begin
          bor_act_d = sw_bor_q;
        end
        BCFG_BOR_OFF: begin
          bor_act_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bor_act_q <= 1'b0;
    end else begin
      bor_act_q <= bor_act_d;
    end
  end

  assign clock_switchover_enable = switch_q;
  assign failsafe_monitor_enable = failsafe_q;
  assign oscillator_select = osc_sel_q;
  assign brownout_threshold_select = bor_thr_q;
  assign brownout_reset_active = bor_act_q;
  assign powerup_delay_run = powerup_delay_timer_run_q;
  assign config_loaded = loaded_q;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic rd_err;

  // configuration bytes are read-only at run time
  always_comb begin
    rd_data = WORD_ZERO;
    rd_err = 1'b0;
    unique case (paddr)
      ADDR_OSC_CFG: begin
        rd_data[7:0] = osc_cfg_q & OSC_IMPL_MASK;
        rd_err = pwrite;
      end
      ADDR_RST_CFG: begin
        rd_data[7:0] = rst_cfg_q & RST_IMPL_MASK;
        rd_err = pwrite;
      end
      ADDR_CTRL: begin
        rd_data[CTRL_SW_BOR_BIT] = sw_bor_q;
      end
      ADDR_STAT: begin
        rd_data[STAT_LOADED_BIT] = loaded_q;
        rd_data[STAT_BOR_ACTIVE_BIT] = bor_act_q;
        rd_data[STAT_POWERUP_DELAY_TIMER_RUN_BIT] = powerup_delay_timer_run_q;
        rd_data[STAT_SLEEP_BIT] = sleep_active;
        rd_err = pwrite;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  // one wait state keeps prdata registered at the cost of a cycle
  always_comb begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = WORD_ZERO;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      pslverr_d = rd_err;
      if (!pwrite) begin
        prdata_d = rd_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= WORD_ZERO;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule : bcfg_top

// ### bcfg_checker_props.sv
// assertion checker for the boot configuration decoder
`timescale 1ns/1ps
module bcfg_checker
  import bcfg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // power state and decoded controls
  input wire logic sleep_active,
  input wire logic clock_switchover_enable,
  input wire logic failsafe_monitor_enable,
  input wire logic [3:0] oscillator_select,
  input wire logic [1:0] brownout_threshold_select,
  input wire logic brownout_reset_active,
  input wire logic powerup_delay_run,
  input wire logic config_loaded
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic done, rd_osc, rd_rst;
  logic [1:0] mode_q, mode_d;
  logic seen_q, seen_d, sw_q, sw_d;
  assign done = psel && penable && pready && !pslverr;
  assign rd_osc = done && !pwrite && paddr == ADDR_OSC_CFG && config_loaded;
  assign rd_rst = done && !pwrite && paddr == ADDR_RST_CFG && config_loaded;
  // mode is learnt from a read, since the pins may move after capture
  always_comb begin
    mode_d = mode_q;
    seen_d = seen_q;
    sw_d = sw_q;
    if (rd_rst) begin
      mode_d = prdata[2:1];
      seen_d = 1'b1;
    end
    if (done && pwrite && paddr == ADDR_CTRL && pstrb[0]) begin
      sw_d = pwdata[0];
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q <= 2'b00;
      seen_q <= 1'b0;
      sw_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      seen_q <= seen_d;
      sw_q <= sw_d;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_OSC_FIELDS: assert property (rd_osc && $past(config_loaded) |->
    prdata[7:0] == {clock_switchover_enable, failsafe_monitor_enable, 2'b00, oscillator_select})
    else $error("osc byte read differs from decoded outputs");
  AST_OSC_UNIMPL: assert property (rd_osc |->
    prdata[5:4] == 2'b00 && prdata[31:8] == 24'h00_0000) else $error("osc spare bits set");
  AST_RST_UNIMPL: assert property (rd_rst |->
    prdata[31:5] == 27'h000_0000) else $error("reset byte spare bits set");
  AST_THRESHOLD: assert property (rd_rst && $past(config_loaded) |->
    prdata[4:3] == brownout_threshold_select) else $error("threshold output wrong");
  AST_POWERUP_DELAY_TIMER: assert property (rd_rst && $past(config_loaded) |->
    prdata[0] == !powerup_delay_run) else $error("power-up delay polarity wrong");
  AST_BOR_ALWAYS: assert property (seen_q && mode_q == 2'b11 |->
    brownout_reset_active) else $error("brown-out not held on");
  AST_BOR_AWAKE: assert property (seen_q && mode_q == 2'b10 |->
    brownout_reset_active == !$past(sleep_active)) else $error("brown-out sleep gating wrong");
  AST_BOR_SW: assert property (seen_q && mode_q == 2'b01 && $stable(sw_q) |->
    brownout_reset_active == sw_q) else $error("brown-out does not follow software");
  AST_BOR_OFF: assert property (seen_q && mode_q == 2'b00 |->
    !brownout_reset_active) else $error("brown-out on while off");
  AST_POWERUP_DELAY_TIMER_FIXED: assert property (config_loaded && $past(config_loaded, 2) |->
    $stable(powerup_delay_run)) else $error("power-up delay moved after load");
endmodule : bcfg_checker

bind bcfg_top bcfg_checker bcfg_checker_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_active, .clock_switchover_enable,
  .failsafe_monitor_enable, .oscillator_select, .brownout_threshold_select,
  .brownout_reset_active, .powerup_delay_run, .config_loaded);

// ### bcfg_testbench.sv
// self-checking testbench of the boot configuration decoder
`timescale 1ns/1ps
module testbench;
  import bcfg_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] nv_osc_byte = 8'h00, nv_rst_byte = 8'h00;
  logic nv_blank = 1'b0, sleep_active = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, clock_switchover_enable, failsafe_monitor_enable;
  logic brownout_reset_active, powerup_delay_run, config_loaded;
  logic [3:0] oscillator_select;
  logic [1:0] brownout_threshold_select;
  logic [7:0] osc_x, rst_x;
  int fail_count = 0, comparisons = 0;

  always #25 mclk = ~mclk;

  bcfg_top bcfg_top_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .nv_osc_byte, .nv_rst_byte, .nv_blank, .sleep_active,
    .clock_switchover_enable, .failsafe_monitor_enable, .oscillator_select,
    .brownout_threshold_select, .brownout_reset_active, .powerup_delay_run, .config_loaded);

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // capture happens once per reset, so each new pattern needs a reset
  task automatic load(input logic [7:0] o, input logic [7:0] r, input logic b);
    @(posedge mclk);
    rst <= 1'b1;
    nv_osc_byte <= o;
    nv_rst_byte <= r;
    nv_blank <= b;
    sleep_active <= 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    do begin
      @(posedge mclk);
    end while (config_loaded !== 1'b1);
    repeat (2) @(posedge mclk);
    osc_x = b ? OSC_UNPROG : (o & OSC_IMPL_MASK);
    rst_x = b ? RST_UNPROG : (r & RST_IMPL_MASK);
  endtask : load

  function automatic logic bor_exp(input logic [1:0] m, input logic slp, input logic sw);
    case (m)
      2'b11: return 1'b1;
      2'b10: return ~slp;
      2'b01: return sw;
      default: return 1'b0;
    endcase
  endfunction : bor_exp

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [7:0] o, r;
    logic e;
    void'($urandom(14451));
    for (int i = 0; i < 24; i++) begin
      o = 8'($urandom);
      r = 8'($urandom);
      // first four cover every brown-out mode with spare bits set
      if (i < 4) r = {3'b111, 2'(i), 2'(i), 1'(i)};
      load(o, r, i == 4);
      if (i == 4) chk("blank select", 32'h0000_0007, 32'(oscillator_select));
      chk("switchover", 32'(osc_x[7]), 32'(clock_switchover_enable));
      chk("failsafe", 32'(osc_x[6]), 32'(failsafe_monitor_enable));
      chk("osc select", 32'(osc_x[3:0]), 32'(oscillator_select));
      chk("threshold", 32'(rst_x[4:3]), 32'(brownout_threshold_select));
      chk("powerup_delay_timer run", 32'(!rst_x[0]), 32'(powerup_delay_run));
      apb(1'b0, ADDR_OSC_CFG, 32'h0000_0000, 4'h0);
      chk("osc byte", {24'h00_0000, osc_x}, rd);
      apb(1'b0, ADDR_RST_CFG, 32'h0000_0000, 4'h0);
      chk("rst byte", {24'h00_0000, rst_x}, rd);
      for (int j = 0; j < 4; j++) begin
        apb(1'b1, ADDR_CTRL, 32'(j % 2), 4'h1);
        @(posedge mclk);
        sleep_active <= 1'(j / 2);
        repeat (2) @(posedge mclk);
        e = bor_exp(rst_x[2:1], 1'(j / 2), 1'(j % 2));
        chk("bor active", 32'(e), 32'(brownout_reset_active));
        chk("powerup_delay_timer held", 32'(!rst_x[0]), 32'(powerup_delay_run));
        apb(1'b0, ADDR_STAT, 32'h0000_0000, 4'h0);
        chk("status", {28'h000_0000, 1'(j / 2), ~rst_x[0], e, 1'b1}, rd);
      end
    end
    // cells moving after capture must not reach the outputs
    nv_osc_byte <= ~osc_x;
    nv_rst_byte <= ~rst_x;
    repeat (6) @(posedge mclk);
    chk("select held", 32'(osc_x[3:0]), 32'(oscillator_select));
    chk("threshold held", 32'(rst_x[4:3]), 32'(brownout_threshold_select));
    // refused and ignored accesses
    apb(1'b0, ADDR_CTRL + 26'h8, 32'h0000_0000, 4'h0);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    apb(1'b1, ADDR_OSC_CFG, 32'hFFFF_FFFF, 4'hF);
    chk("osc write", 32'h0000_0001, 32'(err));
    apb(1'b0, ADDR_OSC_CFG, 32'h0000_0000, 4'h0);
    chk("osc kept", {24'h00_0000, osc_x}, rd);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'h0);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'h0);
    chk("ctrl unstrobed", 32'h0000_0001, rd);
    summarize();
  end

  // watchdog, far beyond the expected run of about 1600 cycles
  initial begin
    #1_000_000;
    fail_count++;
    summarize();
  end
endmodule : testbench
